/* svmon_afe_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// analog front end: dividers, dacs, comparators, reference clock
// ------------------------------------------------------------
module svmon_afe_model
    import svmon_pkg::*;
(
    // clock
    input wire logic mclk_i,
    // from the digital core
    input wire logic [7:0] boost_dac_i,
    input wire logic boost_div_quarter_i,
    input wire logic [5:0] batt_dac_i,
    // scene control
    input wire logic [5:0] batt_level_i,
    input wire logic [15:0] boost_mv_i,
    input wire logic clk_ok_i,
    // to the digital core
    output logic boost_above_o,
    output logic batt_above_o,
    output logic ext_clk_o
);
    logic [7:0] half_cnt_r = 8'h00;
    logic ext_clk_r = 1'b0;
    // battery level is given in codes of 39.06 mV times 16
    assign batt_above_o = (batt_level_i >= batt_dac_i);
    // scaled by ten so the 312.5 and 39.1 mV steps stay integer
    assign boost_above_o = boost_div_quarter_i ?
        (32'(boost_mv_i) * 10 > 32'(boost_dac_i) * 391) :
        (32'(boost_mv_i) * 10 > 32'(boost_dac_i) * 3125);
    // 1.0 MHz reference; an unsuitable source stands still low
    always_ff @(posedge mclk_i)
    begin
        half_cnt_r <= (half_cnt_r == 8'h7C) ? 8'h00 : half_cnt_r + 8'h01;
        ext_clk_r <= clk_ok_i & (ext_clk_r ^ (half_cnt_r == 8'h7C));
    end
    assign ext_clk_o = ext_clk_r;
endmodule

/* svmon_pkg.sv */
package svmon_pkg;
    // ------------------------------------------------------------
    // register offsets (9-bit register index space)
    // ------------------------------------------------------------
    localparam logic [8:0] BOOST_SETPOINT_OFF = 9'h17F;
    localparam logic [8:0] PLL_SETUP_OFF = 9'h1A7;
    localparam logic [8:0] DRIVER_COND_OFF = 9'h1B2;
    localparam logic [8:0] BATT_RESULT_OFF = 9'h1B3;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int PLL_FM_EN_BIT = 0;
    localparam int PLL_BACKUP_BIT = 1;
    localparam int DRV_GS_LOW_BIT = 0;
    localparam int DRV_BP_LOW_BIT = 1;
    localparam int DRV_BP_DIS_EN_BIT = 2;
    localparam int DRV_BP_MON_EN_BIT = 3;
    localparam int DRV_BP_MODE_BIT = 4;
    localparam logic [7:0] BOOST_CODE_RST = 8'h08;
    localparam logic FM_EN_RST = 1'b1;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int REF_PERIOD_NS = 1000;
    localparam int REF_CYC = REF_PERIOD_NS * CLK_MHZ / 1000;
    localparam logic [8:0] REF_MIN_CYC = 9'(REF_CYC * 4 / 5);
    localparam logic [8:0] REF_MAX_CYC = 9'(REF_CYC * 6 / 5);
    localparam logic [3:0] BATT_SETTLE_CYC = 4'h8;
    localparam logic [2:0] FILT_CYC = 3'h4;
    localparam int NSYNC = 6;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic gate_supply_low;
        logic boost_lockout;
        logic boost_above;
        logic batt_above;
        logic ext_clk;
        logic power_on_reset_n;
    } svmon_ana_t;
    typedef enum logic [1:0] {
        BAT_SET = 2'b00,
        BAT_WAIT = 2'b01,
        BAT_LATCH = 2'b10
    } svmon_bat_st_t;
endpackage

/* svmon_top.sv */
`timescale 1ns/1ps
module svmon_top
    import svmon_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // analog front end
    input wire svmon_pkg::svmon_ana_t ana_i,
    output logic [7:0] boost_dac_o,
    output logic boost_div_quarter_o,
    output logic [5:0] batt_dac_o,
    // register port
    input wire logic [8:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // microcore side
    input wire logic mc_dac_wr_i,
    input wire logic [7:0] mc_dac_data_i,
    output logic [5:0] mc_batt_o,
    output logic boost_above_o,
    // drivers
    input wire logic [6:0] hs_in_i,
    input wire logic [7:0] ls_in_i,
    output logic [6:0] hs_cmd_o,
    output logic [7:0] ls_cmd_o,
    // supply and clock control
    output logic cp_run_o,
    output logic pll_backup_o,
    output logic pll_fm_en_o,
    output logic cram_clk_o,
    output logic dram_clk_o
);
    import svmon_pkg::*;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    assign raw_w = ana_i;
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge mclk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end
                else
                begin
                    meta_r[gi] <= raw_w[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate
    svmon_ana_t s_w;
    assign s_w = sync_r;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] boost_code_r;
    logic fm_en_r;
    logic bp_dis_en_r;
    logic bp_mon_en_r;
    logic bp_mode_r;
    logic [5:0] batt_res_r;
    logic backup_r;
    logic bp_low_r;

    function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
        hit = (a == off);
    endfunction

    wire wr_boost_w = reg_wr_i && hit(reg_addr_i, BOOST_SETPOINT_OFF);
    wire wr_pll_w = reg_wr_i && hit(reg_addr_i, PLL_SETUP_OFF);
    wire wr_drv_w = reg_wr_i && hit(reg_addr_i, DRIVER_COND_OFF);

    // microcode write wins over a register write in the same cycle
    logic [7:0] boost_code_nxt;
    assign boost_code_nxt = mc_dac_wr_i ? mc_dac_data_i :
                            wr_boost_w ? reg_wdata_i[7:0] : boost_code_r;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boost_code_r <= BOOST_CODE_RST;
            fm_en_r <= FM_EN_RST;
            bp_dis_en_r <= 1'b0;
            bp_mon_en_r <= 1'b0;
            bp_mode_r <= 1'b0;
        end
        else
        begin
            boost_code_r <= boost_code_nxt;
            if (wr_pll_w)
            begin
                fm_en_r <= reg_wdata_i[PLL_FM_EN_BIT];
            end
            if (wr_drv_w)
            begin
                bp_dis_en_r <= reg_wdata_i[DRV_BP_DIS_EN_BIT];
                bp_mon_en_r <= reg_wdata_i[DRV_BP_MON_EN_BIT];
                bp_mode_r <= reg_wdata_i[DRV_BP_MODE_BIT];
            end
        end
    end

    logic [15:0] rd_mux_w;
    assign rd_mux_w = hit(reg_addr_i, BOOST_SETPOINT_OFF) ? {8'h00, boost_code_r} :
                      hit(reg_addr_i, PLL_SETUP_OFF) ? {14'h0000, backup_r, fm_en_r} :
                      hit(reg_addr_i, DRIVER_COND_OFF) ?
                          {11'h000, bp_mode_r, bp_mon_en_r, bp_dis_en_r, bp_low_r, s_w.gate_supply_low} :
                      hit(reg_addr_i, BATT_RESULT_OFF) ? {10'h000, batt_res_r} : 16'h0000;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 16'h0000;
        else
            reg_rdata_o <= rd_mux_w;
    end

    // ------------------------------------------------------------
    // boost monitor
    // ------------------------------------------------------------
    // one filter serves both modes, so a mode switch keeps its history
    logic [2:0] filt_cnt_r;
    logic filt_r;
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            filt_cnt_r <= 3'h0;
            filt_r <= 1'b0;
        end
        else if (s_w.boost_above == filt_r)
            filt_cnt_r <= 3'h0;
        else if (filt_cnt_r == FILT_CYC - 3'h1)
        begin
            filt_cnt_r <= 3'h0;
            filt_r <= s_w.boost_above;
        end
        else
            filt_cnt_r <= filt_cnt_r + 3'h1;
    end

    // code step is 312.5 mV at 1/32 and 39.1 mV at 1/4 in the analog divider
    assign boost_dac_o = boost_code_r;
    assign boost_div_quarter_o = bp_mode_r;
    assign boost_above_o = filt_r;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            bp_low_r <= 1'b0;
        else
            bp_low_r <= bp_mon_en_r && !filt_r;
    end

    // ------------------------------------------------------------
    // battery measurement
    // ------------------------------------------------------------
    // code times 39.06 mV times 16 is the battery level, about 5 V to 36 V
    svmon_bat_st_t bat_st_r;
    logic [2:0] bit_r;
    logic [3:0] settle_r;
    logic [5:0] trial_r;
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bat_st_r <= BAT_SET;
            bit_r <= 3'h5;
            settle_r <= 4'h0;
            trial_r <= 6'h00;
            batt_res_r <= 6'h00;
        end
        else
        begin
            case (bat_st_r)
                BAT_SET:
                begin
                    trial_r[bit_r] <= 1'b1;
                    settle_r <= 4'h0;
                    bat_st_r <= BAT_WAIT;
                end
                BAT_WAIT:
                begin
                    if (settle_r == BATT_SETTLE_CYC)
                    begin
                        if (!s_w.batt_above)
                            trial_r[bit_r] <= 1'b0;
                        if (bit_r == 3'h0)
                            bat_st_r <= BAT_LATCH;
                        else
                        begin
                            bit_r <= bit_r - 3'h1;
                            bat_st_r <= BAT_SET;
                        end
                    end
                    else
                        settle_r <= settle_r + 4'h1;
                end
                BAT_LATCH:
                begin
                    batt_res_r <= trial_r;
                    trial_r <= 6'h00;
                    bit_r <= 3'h5;
                    bat_st_r <= BAT_SET;
                end
                default:
                    bat_st_r <= BAT_SET;
            endcase
        end
    end
    assign batt_dac_o = trial_r;
    assign mc_batt_o = batt_res_r;

    // ------------------------------------------------------------
    // driver gating
    // ------------------------------------------------------------
    wire hs_block_w = s_w.gate_supply_low || s_w.boost_lockout || (bp_low_r && bp_dis_en_r);
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hs_cmd_o <= 7'h00;
            ls_cmd_o <= 8'h00;
        end
        else
        begin
            hs_cmd_o <= hs_block_w ? 7'h00 : hs_in_i;
            ls_cmd_o <= s_w.gate_supply_low ? 8'h00 : ls_in_i;
        end
    end

    // ------------------------------------------------------------
    // charge pump and clocks
    // ------------------------------------------------------------
    // the raw reset input cuts the pump at once; release waits for the sync
    assign cp_run_o = ana_i.power_on_reset_n && s_w.power_on_reset_n;

    logic clk_prev_r;
    logic [8:0] per_r;
    wire clk_edge_w = s_w.ext_clk && !clk_prev_r;
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            clk_prev_r <= 1'b0;
            per_r <= 9'h000;
            backup_r <= 1'b1;
        end
        else
        begin
            clk_prev_r <= s_w.ext_clk;
            if (clk_edge_w)
            begin
                per_r <= 9'h000;
                backup_r <= (per_r < REF_MIN_CYC) || (per_r > REF_MAX_CYC);
            end
            else if (per_r > REF_MAX_CYC)
                backup_r <= 1'b1;
            else
                per_r <= per_r + 9'h001;
        end
    end
    assign pll_backup_o = backup_r;
    assign pll_fm_en_o = fm_en_r;
    // inverted clocks let the rams sample mid cycle of the logic clock
    assign cram_clk_o = ~mclk_i;
    assign dram_clk_o = ~mclk_i;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    gs_off_hs_a: assert property (s_w.gate_supply_low |=> hs_cmd_o == 7'h00)
        else $error("high side on during gate supply low");
    gs_off_ls_a: assert property (s_w.gate_supply_low |=> ls_cmd_o == 8'h00)
        else $error("low side on during gate supply low");
    lockout_hs_a: assert property (s_w.boost_lockout |=> hs_cmd_o == 7'h00)
        else $error("high side on during boost lockout");
    bp_gate_a: assert property (!hs_block_w |=> hs_cmd_o == $past(hs_in_i))
        else $error("high side blocked without cause");
    bp_flag_a: assert property (bp_mon_en_r && !filt_r |=> bp_low_r)
        else $error("boost low flag missing");
    filt_hold_a: assert property ($changed(filt_r) |-> $past(s_w.boost_above, 4) == filt_r)
        else $error("filter changed too early");
    batt_latch_a: assert property (bat_st_r == BAT_LATCH |=> batt_res_r == $past(trial_r))
        else $error("battery result not latched");
    batt_cycle_a: assert property (bat_st_r == BAT_LATCH |-> ##[50:70] bat_st_r == BAT_LATCH)
        else $error("battery measurement stalled");
    cp_stop_a: assert property (!ana_i.power_on_reset_n |-> !cp_run_o)
        else $error("charge pump runs in reset");
    fm_reset_a: assert property ($rose(fm_en_r) |-> $past(wr_pll_w))
        else $error("modulation enabled without write");
    clk_lost_a: assert property (per_r > REF_MAX_CYC |=> backup_r)
        else $error("backup clock not selected");

    batt_done_c: cover property (bat_st_r == BAT_LATCH && trial_r != 6'h00);
    bp_block_c: cover property (bp_low_r && bp_dis_en_r && hs_in_i != 7'h00);
    clk_good_c: cover property ($fell(backup_r));
    mc_dac_c: cover property (mc_dac_wr_i && wr_boost_w);
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import svmon_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic gs_low = 1'b0, lockout = 1'b0, por_n = 1'b1, clk_ok = 1'b1;
    logic reg_wr = 1'b0, mc_wr = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [15:0] reg_wdata = 16'h0000, boost_mv = 16'h0000, rdata;
    logic [7:0] mc_data = 8'h00, ls_in = 8'h00, boost_dac, ls_cmd;
    logic [6:0] hs_in = 7'h00, hs_cmd;
    logic [5:0] batt_level = 6'h08, batt_dac, mc_batt;
    logic boost_above, batt_above, ext_clk, quarter, above_f, cp_run, backup, fm_en, cram, dram;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 39;
    svmon_ana_t ana;
    assign ana = {gs_low, lockout, boost_above, batt_above, ext_clk, por_n};
    initial
    begin
        forever #2 mclk_i = ~mclk_i;
    end
    svmon_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .ana_i(ana), .boost_dac_o(boost_dac),
        .boost_div_quarter_o(quarter), .batt_dac_o(batt_dac), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata), .mc_dac_wr_i(mc_wr), .mc_dac_data_i(mc_data),
        .mc_batt_o(mc_batt), .boost_above_o(above_f), .hs_in_i(hs_in), .ls_in_i(ls_in), .hs_cmd_o(hs_cmd),
        .ls_cmd_o(ls_cmd), .cp_run_o(cp_run), .pll_backup_o(backup), .pll_fm_en_o(fm_en),
        .cram_clk_o(cram), .dram_clk_o(dram));
    svmon_afe_model afe (.mclk_i(mclk_i), .boost_dac_i(boost_dac), .boost_div_quarter_i(quarter),
        .batt_dac_i(batt_dac), .batt_level_i(batt_level), .boost_mv_i(boost_mv), .clk_ok_i(clk_ok),
        .boost_above_o(boost_above), .batt_above_o(batt_above), .ext_clk_o(ext_clk));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask
    // read data is registered: it shows the address of the previous cycle
    task automatic rd_chk(input logic [8:0] a, input logic [15:0] e, input string what);
        @(posedge mclk_i);
        reg_addr <= a;
        @(posedge mclk_i);
        #1 chk(rdata, e, what);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // threshold in mV for a set-point code: 312.5 mV steps at 1/32, 39.1 mV steps at 1/4
    function automatic int thr_mv(input logic [7:0] code, input logic quarter_mode);
        thr_mv = quarter_mode ? int'(code) * 391 / 10 : int'(code) * 3125 / 10;
    endfunction
    // driver condition word built from the package field positions
    function automatic logic [15:0] cond_word(input logic mode, input logic mon, input logic dis,
        input logic low, input logic gs);
        cond_word = 16'h0000;
        cond_word[DRV_BP_MODE_BIT] = mode;
        cond_word[DRV_BP_MON_EN_BIT] = mon;
        cond_word[DRV_BP_DIS_EN_BIT] = dis;
        cond_word[DRV_BP_LOW_BIT] = low;
        cond_word[DRV_GS_LOW_BIT] = gs;
    endfunction
    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge mclk_i);
        num_errors++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] c;
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        cyc(1);
        chk(16'(boost_dac), 16'(BOOST_CODE_RST), "boost reset");
        chk(16'(fm_en), 16'(FM_EN_RST), "fm reset");
        chk(16'({cram, dram}), 16'h0000, "ram clocks high phase");
        #2 chk(16'({cram, dram}), 16'h0003, "ram clocks low phase");
        wr(9'h0FF, 16'hFFFF);
        rd_chk(9'h0FF, 16'h0000, "unmapped read");
        cyc(700);
        rd_chk(PLL_SETUP_OFF, 16'h0001, "pll setup");
        // set points stay within 08h..D0h, the overshoot-safe span
        for (int i = 0; i < 4; i++)
        begin
            c = 8'h08 + 8'($unsigned($random(seed)) % 201);
            wr(BOOST_SETPOINT_OFF, {8'h00, c});
            rd_chk(BOOST_SETPOINT_OFF, {8'h00, c}, "boost code");
            @(posedge mclk_i);
            boost_mv <= 16'(thr_mv(c, 1'b0) + ((i % 2) ? 200 : -200));
            cyc(12);
            chk(16'(above_f), 16'(i % 2), "boost above");
        end
        @(posedge mclk_i);
        mc_wr <= 1'b1;
        mc_data <= 8'hA5;
        reg_addr <= BOOST_SETPOINT_OFF;
        reg_wr <= 1'b1;
        reg_wdata <= 16'h0033;
        @(posedge mclk_i);
        mc_wr <= 1'b0;
        reg_wr <= 1'b0;
        cyc(0);
        chk(16'(boost_dac), 16'h00A5, "microcode dac");
        wr(PLL_SETUP_OFF, 16'h0000);
        cyc(0);
        chk(16'(fm_en), 16'h0000, "fm off");
        wr(PLL_SETUP_OFF, 16'h0001);
        cyc(0);
        chk(16'(fm_en), 16'h0001, "fm on again");
        // both ends of the span, then a random level
        for (int i = 0; i < 3; i++)
        begin
            @(posedge mclk_i);
            batt_level <= (i == 0) ? 6'h08 : (i == 1) ? 6'h39 : 6'(6'h08 + $unsigned($random(seed)) % 50);
            cyc(130);
            chk(16'(mc_batt), 16'(batt_level), "batt map");
            rd_chk(BATT_RESULT_OFF, 16'(batt_level), "batt reg");
        end
        // 7Fh gives about 4.97 V: below 5.0 V, above the 4.7 V pump limit
        wr(BOOST_SETPOINT_OFF, 16'h007F);
        wr(DRIVER_COND_OFF, cond_word(1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
        @(posedge mclk_i);
        boost_mv <= 16'd4800;
        hs_in <= 7'($random(seed));
        ls_in <= 8'($random(seed));
        cyc(12);
        chk(16'(quarter), 16'h0001, "divider quarter");
        rd_chk(DRIVER_COND_OFF, cond_word(1'b1, 1'b1, 1'b0, 1'b1, 1'b0), "low flag");
        chk(16'(hs_cmd), 16'(hs_in), "hs ungated");
        wr(DRIVER_COND_OFF, cond_word(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
        cyc(3);
        chk(16'({hs_cmd, ls_cmd}), 16'({7'h00, ls_in}), "boost low gate");
        @(posedge mclk_i);
        boost_mv <= 16'd5200;
        cyc(14);
        chk(16'(hs_cmd), 16'(hs_in), "flag clear");
        @(posedge mclk_i);
        gs_low <= 1'b1;
        cyc(5);
        chk(16'({hs_cmd, ls_cmd}), 16'h0000, "gate supply low");
        rd_chk(DRIVER_COND_OFF, cond_word(1'b1, 1'b1, 1'b1, 1'b0, 1'b1), "gs flag");
        @(posedge mclk_i);
        gs_low <= 1'b0;
        lockout <= 1'b1;
        cyc(5);
        chk(16'({hs_cmd, ls_cmd}), 16'({7'h00, ls_in}), "lockout");
        @(posedge mclk_i);
        lockout <= 1'b0;
        por_n <= 1'b0;
        cyc(0);
        chk(16'(cp_run), 16'h0000, "pump held");
        @(posedge mclk_i);
        por_n <= 1'b1;
        cyc(5);
        chk(16'(cp_run), 16'h0001, "pump runs");
        @(posedge mclk_i);
        clk_ok <= 1'b0;
        cyc(400);
        chk(16'(backup), 16'h0001, "backup on");
        @(posedge mclk_i);
        clk_ok <= 1'b1;
        cyc(700);
        chk(16'(backup), 16'h0000, "backup off");
        end_of_test();
    end
endmodule
